// >>> output_power_sequencer.sv
// output turn-on, turn-off and power-up timeout sequencer
// assumes vout_code_i, uv_limit_reached_i, bias_ok_i, other_fault_i and
// fault_clear_i come from logic on clock_i; run_request_i is a pin
//
// Contract
// - keep a 16-bit power-good assert level, reset 0114h.
// - keep a 16-bit power-good release level, reset 0105h.
// - power-good levels lie in 0.24 V to 14 V, 1.953 mV steps.
// - after start, wait the turn-on delay before rising; reset 0000h.
// - millisecond settings: 11-bit mantissa, exponent fixed at zero.
// - millisecond settings 0 to 127; other writes dropped, flagged.
// - ramp reaches regulation within the rise time; reset 0005h.
// - timeout fault if undervoltage limit unmet within limit; 0014h.
// - timeout action byte: response 7:6, retry 5:3, delay 2:0; B9h.
// - response 10 retry 111: retry forever until off, bias, fault.
// - response 10 retry 000: shut down, no restart, until cleared.
// - response 10 retry 001: one restart after 0/20/30/40 ms.
// - after stop, keep energy transfer for the turn-off delay.
// - turn-off delay resets to 0000h, stopping at once.
`timescale 1ns/1ps
`default_nettype none
`include "output_power_sequencer_regs.svh"
module output_power_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned MS_CYCLES   = `TICK_CYCLES,
  parameter logic [6:0]  TARGET_ADDR = 7'h2A
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // management bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // on/off and fault inputs
  input  wire logic        run_request_i,
  input  wire logic        bias_ok_i,
  input  wire logic        other_fault_i,
  input  wire logic        fault_clear_i,
  // output monitor
  input  wire logic [15:0] vout_code_i,
  input  wire logic        uv_limit_reached_i,
  // sequencer outputs
  output logic             output_enable_o,
  output logic             ramp_active_o,
  output logic [7:0]       ramp_elapsed_o,
  output logic             power_good_o,
  output logic             timeout_fault_o,
  output logic             config_error_o
);

  function automatic logic ms_ok(input logic [15:0] v);
    return (v[`MS_EXP_MSB:`MS_EXP_LSB] == `MS_EXP_VALUE)
         && (v[`MS_MANT_MSB:0] <= `MS_MANT_MAX);
  endfunction

  function automatic logic pg_ok(input logic [15:0] v);
    return (v >= `PG_MIN_CODE) && (v <= `PG_MAX_CODE);
  endfunction

  function automatic logic is_ms_cmd(input logic [7:0] c);
    return (c == `TURN_ON_DELAY_CMD) || (c == `TURN_ON_RISE_CMD)
        || (c == `PU_TIMEOUT_LIMIT_CMD) || (c == `TURN_OFF_DELAY_CMD);
  endfunction

  function automatic logic is_pg_cmd(input logic [7:0] c);
    return (c == `PG_ASSERT_LEVEL_CMD) || (c == `PG_RELEASE_LEVEL_CMD);
  endfunction

  function automatic logic [7:0] retry_delay(input logic [2:0] code);
    case (code)
      3'h0:    return `RETRY_DELAY_0_MS;
      3'h1:    return `RETRY_DELAY_1_MS;
      3'h2:    return `RETRY_DELAY_2_MS;
      default: return `RETRY_DELAY_3_MS;
    endcase
  endfunction

  // bus target
  logic        wr_valid;
  logic [1:0]  wr_len;
  logic [7:0]  cmd;
  logic [15:0] wr_data;
  logic [15:0] rd_data;

  pmbus_target #(
    .TARGET_ADDR (TARGET_ADDR)
  ) u_target (
    .clock_i    (clock_i),
    .resetn_i   (resetn_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_o      (sda_o),
    .sda_oe_o   (sda_oe_o),
    .wr_valid_o (wr_valid),
    .wr_len_o   (wr_len),
    .cmd_o      (cmd),
    .wr_data_o  (wr_data),
    .rd_data_i  (rd_data)
  );

  // configuration registers
  logic [15:0] pg_assert_reg, pg_release_reg;
  logic [15:0] on_delay_reg, rise_reg, limit_reg, off_delay_reg;
  logic [7:0]  action_reg;

  wire word_wr   = wr_valid & (wr_len == 2'h2);
  wire byte_wr   = wr_valid & (wr_len == 2'h1);
  wire clear_cmd = wr_valid & (wr_len == 2'h0) & (cmd == `CLEAR_FAULTS_CMD);
  wire ms_good   = word_wr & is_ms_cmd(cmd) & ms_ok(wr_data);
  wire pg_good   = word_wr & is_pg_cmd(cmd) & pg_ok(wr_data);
  wire act_good  = byte_wr & (cmd == `PU_TIMEOUT_ACTION_CMD);
  wire wr_bad    = wr_valid & (is_ms_cmd(cmd) | is_pg_cmd(cmd))
                 & ~ms_good & ~pg_good;
  wire fault_clr = fault_clear_i | clear_cmd;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pg_assert_reg  <= `PG_ASSERT_LEVEL_RESET;
      pg_release_reg <= `PG_RELEASE_LEVEL_RESET;
      on_delay_reg   <= `TURN_ON_DELAY_RESET;
      rise_reg       <= `TURN_ON_RISE_RESET;
      limit_reg      <= `PU_TIMEOUT_LIMIT_RESET;
      action_reg     <= `PU_TIMEOUT_ACTION_RESET;
      off_delay_reg  <= `TURN_OFF_DELAY_RESET;
    end else begin
      if (pg_good && cmd == `PG_ASSERT_LEVEL_CMD) begin
        pg_assert_reg <= wr_data;
      end
      if (pg_good && cmd == `PG_RELEASE_LEVEL_CMD) begin
        pg_release_reg <= wr_data;
      end
      if (ms_good && cmd == `TURN_ON_DELAY_CMD) begin
        on_delay_reg <= wr_data;
      end
      if (ms_good && cmd == `TURN_ON_RISE_CMD) begin
        rise_reg <= wr_data;
      end
      if (ms_good && cmd == `PU_TIMEOUT_LIMIT_CMD) begin
        limit_reg <= wr_data;
      end
      if (ms_good && cmd == `TURN_OFF_DELAY_CMD) begin
        off_delay_reg <= wr_data;
      end
      if (act_good) begin
        action_reg <= wr_data[7:0];
      end
    end
  end

  // sequencer
  seq_state_t state_reg, state_next;
  logic [7:0] ms_cnt_reg;
  logic       run_s1, run_s2;
  logic       retry_used_reg, tick;

  wire       kill      = ~bias_ok_i | other_fault_i;
  wire [1:0] resp      = action_reg[`RESP_MSB:`RESP_LSB];
  wire [2:0] retry     = action_reg[`RETRY_MSB:`RETRY_LSB];
  wire [7:0] wait_ms   = retry_delay(action_reg[`DELAY_MSB:`DELAY_LSB]);
  wire       rise_done = uv_limit_reached_i & (ms_cnt_reg >= rise_reg[7:0]);
  wire       tout_event = (state_reg == seq_rising) & ~kill & run_s2
                        & ~uv_limit_reached_i
                        & (ms_cnt_reg >= limit_reg[7:0]);
  wire       do_retry  = (retry == `RETRY_FOREVER)
                       | ((retry == `RETRY_ONCE) & ~retry_used_reg);
  wire       phase_new = (state_next != state_reg);
  wire       en_next   = (state_next == seq_rising)
                       | (state_next == seq_regulate)
                       | (state_next == seq_off_delay);

  ms_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .clock_i   (clock_i),
    .resetn_i  (resetn_i),
    .restart_i (phase_new),
    .tick_o    (tick)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      seq_off: begin
        if (run_s2 && !kill) state_next = seq_on_delay;
      end
      seq_on_delay: begin
        if (kill || !run_s2) state_next = seq_off;
        else if (ms_cnt_reg >= on_delay_reg[7:0])
          state_next = seq_rising;
      end
      seq_rising: begin
        if (kill) state_next = seq_off;
        else if (!run_s2) state_next = seq_off_delay;
        else if (rise_done) state_next = seq_regulate;
        else if (tout_event) begin
          if (resp != `RESP_SHUTDOWN) state_next = seq_regulate;
          else if (do_retry) state_next = seq_retry_wait;
          else state_next = seq_latched;
        end
      end
      seq_regulate: begin
        if (kill) state_next = seq_off;
        else if (!run_s2) state_next = seq_off_delay;
      end
      seq_off_delay: begin
        if (kill || ms_cnt_reg >= off_delay_reg[7:0])
          state_next = seq_off;
      end
      seq_retry_wait: begin
        if (kill || !run_s2) state_next = seq_off;
        else if (ms_cnt_reg >= wait_ms) state_next = seq_on_delay;
      end
      seq_latched: begin
        if (fault_clr) state_next = seq_off;
      end
      default: state_next = seq_off;
    endcase
  end

  // hysteresis: hold while at or above release level
  wire pg_next = en_next & (power_good_o
               ? (vout_code_i >= pg_release_reg)
               : (vout_code_i >= pg_assert_reg));

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_s1          <= 1'b0;
      run_s2          <= 1'b0;
      state_reg       <= seq_off;
      ms_cnt_reg      <= 8'h00;
      retry_used_reg  <= 1'b0;
      output_enable_o <= 1'b0;
      ramp_active_o   <= 1'b0;
      ramp_elapsed_o  <= 8'h00;
      power_good_o    <= 1'b0;
      timeout_fault_o <= 1'b0;
      config_error_o  <= 1'b0;
    end else begin
      run_s1    <= run_request_i;
      run_s2    <= run_s1;
      state_reg <= state_next;
      if (phase_new) ms_cnt_reg <= 8'h00;
      else if (tick && ms_cnt_reg != 8'hFF)
        ms_cnt_reg <= ms_cnt_reg + 8'h01;
      if (state_reg == seq_off) retry_used_reg <= 1'b0;
      else if (state_next == seq_retry_wait) retry_used_reg <= 1'b1;
      output_enable_o <= en_next;
      ramp_active_o   <= (state_next == seq_rising)
                       & (ms_cnt_reg < rise_reg[7:0]);
      ramp_elapsed_o  <= (state_reg == seq_rising) ? ms_cnt_reg : 8'h00;
      power_good_o    <= pg_next;
      // a new event outweighs a clear in the same cycle
      if (tout_event) timeout_fault_o <= 1'b1;
      else if (fault_clr) timeout_fault_o <= 1'b0;
      if (wr_bad) config_error_o <= 1'b1;
      else if (fault_clr) config_error_o <= 1'b0;
    end
  end

  // readback; unknown commands answer all ones
  wire [15:0] status_word = {3'h0, retry_used_reg, config_error_o,
                             timeout_fault_o, output_enable_o,
                             power_good_o, 1'b0, state_reg};
  assign rd_data =
      (cmd == `PG_ASSERT_LEVEL_CMD)   ? pg_assert_reg  :
      (cmd == `PG_RELEASE_LEVEL_CMD)  ? pg_release_reg :
      (cmd == `TURN_ON_DELAY_CMD)     ? on_delay_reg   :
      (cmd == `TURN_ON_RISE_CMD)      ? rise_reg       :
      (cmd == `PU_TIMEOUT_LIMIT_CMD)  ? limit_reg      :
      (cmd == `PU_TIMEOUT_ACTION_CMD) ? {8'h00, action_reg} :
      (cmd == `TURN_OFF_DELAY_CMD)    ? off_delay_reg  :
      (cmd == `SEQ_STATUS_CMD)        ? status_word    : 16'hFFFF;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  a_pg_assert_level: assert property ($rose(power_good_o)
    |-> $past(vout_code_i) >= $past(pg_assert_reg))
    else $error("power good rose below assert level");
  a_pg_release_level: assert property (
    power_good_o && en_next && vout_code_i >= pg_release_reg
    |=> power_good_o)
    else $error("power good dropped above release level");
  a_pg_level_range: assert property (pg_ok(pg_assert_reg)
    && pg_ok(pg_release_reg))
    else $error("power good level out of span");
  a_on_delay_wait: assert property ($rose(state_reg == seq_rising)
    |-> $past(ms_cnt_reg) >= $past(on_delay_reg[7:0]))
    else $error("rise began before turn-on delay");
  a_ms_format: assert property (ms_ok(on_delay_reg) && ms_ok(rise_reg)
    && ms_ok(limit_reg) && ms_ok(off_delay_reg))
    else $error("millisecond setting out of format");
  a_bad_write_dropped: assert property (wr_bad |=> config_error_o
    && $stable(on_delay_reg) && $stable(rise_reg)
    && $stable(limit_reg) && $stable(off_delay_reg))
    else $error("bad write stored or not flagged");
  a_rise_complete: assert property (state_reg == seq_rising && run_s2
    && !kill && rise_done |=> state_reg == seq_regulate
    ##1 output_enable_o)
    else $error("rise did not complete");
  a_timeout_shutdown: assert property (tout_event
    && resp == `RESP_SHUTDOWN |=> timeout_fault_o
    && !output_enable_o)
    else $error("timeout did not shut down");
  a_retry_forever: assert property (tout_event
    && resp == `RESP_SHUTDOWN && retry == `RETRY_FOREVER
    |=> state_reg == seq_retry_wait)
    else $error("continuous retry not taken");
  a_no_retry_latch: assert property (tout_event
    && resp == `RESP_SHUTDOWN && retry == `RETRY_NONE
    |=> state_reg == seq_latched)
    else $error("no-retry response did not latch");
  a_single_retry: assert property (tout_event
    && resp == `RESP_SHUTDOWN && retry == `RETRY_ONCE
    |=> (state_reg == seq_latched) == $past(retry_used_reg))
    else $error("single retry miscounted");
  a_off_delay_hold: assert property (state_reg == seq_off_delay && !kill
    && ms_cnt_reg < off_delay_reg[7:0] |=> output_enable_o)
    else $error("energy transfer stopped early");
  a_off_delay_zero: assert property ($rose(state_reg == seq_off_delay)
    && off_delay_reg == 16'h0000 |=> state_reg == seq_off)
    else $error("zero turn-off delay not immediate");
  a_ms_restart: assert property (state_reg != $past(state_reg)
    |-> ms_cnt_reg == 8'h00)
    else $error("phase counter not restarted");

endmodule
`default_nettype wire

// >>> output_power_sequencer_regs.svh
// command codes, field positions, reset values and timing counts
// assumes inclusion by bare name from the sequencer and its helpers
`ifndef OUTPUT_POWER_SEQUENCER_REGS_SVH
`define OUTPUT_POWER_SEQUENCER_REGS_SVH

`define CLEAR_FAULTS_CMD        8'h03
`define PG_ASSERT_LEVEL_CMD     8'h5E
`define PG_RELEASE_LEVEL_CMD    8'h5F
`define TURN_ON_DELAY_CMD       8'h60
`define TURN_ON_RISE_CMD        8'h61
`define PU_TIMEOUT_LIMIT_CMD    8'h62
`define PU_TIMEOUT_ACTION_CMD   8'h63
`define TURN_OFF_DELAY_CMD      8'h64
`define SEQ_STATUS_CMD          8'hD0

`define PG_ASSERT_LEVEL_RESET   16'h0114
`define PG_RELEASE_LEVEL_RESET  16'h0105
`define TURN_ON_DELAY_RESET     16'h0000
`define TURN_ON_RISE_RESET      16'h0005
`define PU_TIMEOUT_LIMIT_RESET  16'h0014
`define PU_TIMEOUT_ACTION_RESET 8'hB9
`define TURN_OFF_DELAY_RESET    16'h0000

`define RESP_MSB                7
`define RESP_LSB                6
`define RETRY_MSB               5
`define RETRY_LSB               3
`define DELAY_MSB               2
`define DELAY_LSB               0
`define RESP_SHUTDOWN           2'h2
`define RETRY_NONE              3'h0
`define RETRY_ONCE              3'h1
`define RETRY_FOREVER           3'h7

`define MS_EXP_MSB              15
`define MS_EXP_LSB              11
`define MS_EXP_VALUE            5'h00
`define MS_MANT_MSB             10
`define MS_MANT_MAX             11'h07F

// 0.24 V and 14 V in 1.953 mV steps
`define PG_MIN_CODE             16'h007B
`define PG_MAX_CODE             16'h1C00

`define RETRY_DELAY_0_MS        8'h00
`define RETRY_DELAY_1_MS        8'h14
`define RETRY_DELAY_2_MS        8'h1E
`define RETRY_DELAY_3_MS        8'h28

`define CLOCK_FREQ_KHZ          100000
`define TICK_PERIOD_MS          1
`define TICK_CYCLES             (`TICK_PERIOD_MS * `CLOCK_FREQ_KHZ)

`endif

// >>> seq_pkg.sv
// types shared by the sequencer and its bus target
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package seq_pkg;

  typedef enum logic [6:0] {
    seq_off        = 7'h01,
    seq_on_delay   = 7'h02,
    seq_rising     = 7'h04,
    seq_regulate   = 7'h08,
    seq_off_delay  = 7'h10,
    seq_retry_wait = 7'h20,
    seq_latched    = 7'h40
  } seq_state_t;

  typedef enum logic [5:0] {
    bus_idle   = 6'h01,
    bus_addr   = 6'h02,
    bus_cmd    = 6'h04,
    bus_wdata  = 6'h08,
    bus_rdata  = 6'h10,
    bus_ignore = 6'h20
  } bus_state_t;

endpackage
`default_nettype wire

// >>> ms_tick.sv
// one-cycle pulse every millisecond, phase restartable
// assumes restart_i comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module ms_tick #(
  parameter int unsigned MS_CYCLES = 100000
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic resetn_i,
  // control
  input  wire logic restart_i,
  output logic      tick_o
);

  logic [31:0] cnt_reg;
  wire         wrap = (cnt_reg == 32'(MS_CYCLES - 1));

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= 32'h0000_0000;
      tick_o  <= 1'b0;
    end else if (restart_i) begin
      cnt_reg <= 32'h0000_0000;
      tick_o  <= 1'b0;
    end else begin
      cnt_reg <= wrap ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
      tick_o  <= wrap;
    end
  end

endmodule
`default_nettype wire

// >>> pmbus_target.sv
// byte and word command target on the two-wire management bus
// assumes scl and sda are pins, sampled here through two flip-flops
`timescale 1ns/1ps
`default_nettype none
module pmbus_target
  import seq_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = 7'h2A
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // command side
  output logic             wr_valid_o,
  output logic [1:0]       wr_len_o,
  output logic [7:0]       cmd_o,
  output logic [15:0]      wr_data_o,
  input  wire logic [15:0] rd_data_i
);

  logic       scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  bus_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, tx_reg;
  logic       in_ack_reg, mack_reg;

  wire scl_rise  = scl_s2 & ~scl_s3;
  wire scl_fall  = ~scl_s2 & scl_s3;
  wire start_seen = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire stop_seen  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  wire byte_done = (bit_cnt_reg == 4'h8);
  wire addr_hit  = (shift_reg[7:1] == TARGET_ADDR);
  wire rx_state  = (state_reg == bus_addr) | (state_reg == bus_cmd)
                 | (state_reg == bus_wdata);
  wire [7:0] tx_byte = (wr_len_o == 2'h0) ? rd_data_i[7:0]
                     : (wr_len_o == 2'h1) ? rd_data_i[15:8] : 8'hFF;
  wire [1:0] idx_inc = (wr_len_o == 2'h3) ? wr_len_o : wr_len_o + 2'h1;

  // open drain: only ever pulls low
  assign sda_o = 1'b0;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
      state_reg   <= bus_idle;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      in_ack_reg  <= 1'b0;
      mack_reg    <= 1'b0;
      sda_oe_o    <= 1'b0;
      wr_valid_o  <= 1'b0;
      wr_len_o    <= 2'h0;
      cmd_o       <= 8'h00;
      wr_data_o   <= 16'h0000;
    end else begin
      {scl_s3, scl_s2, scl_s1} <= {scl_s2, scl_s1, scl_i};
      {sda_s3, sda_s2, sda_s1} <= {sda_s2, sda_s1, sda_i};
      wr_valid_o <= 1'b0;
      if (start_seen) begin
        state_reg   <= bus_addr;
        bit_cnt_reg <= 4'h0;
        in_ack_reg  <= 1'b0;
        sda_oe_o    <= 1'b0;
      end else if (stop_seen) begin
        wr_valid_o <= (state_reg == bus_wdata);
        state_reg  <= bus_idle;
        in_ack_reg <= 1'b0;
        sda_oe_o   <= 1'b0;
      end else if (scl_rise) begin
        if (in_ack_reg) begin
          mack_reg <= ~sda_s2;
        end else if (rx_state && !byte_done) begin
          shift_reg   <= {shift_reg[6:0], sda_s2};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
      end else if (scl_fall) begin
        if (in_ack_reg) begin
          in_ack_reg  <= 1'b0;
          bit_cnt_reg <= 4'h0;
          sda_oe_o    <= 1'b0;
          if (state_reg == bus_rdata) begin
            if (mack_reg) begin
              sda_oe_o    <= ~tx_byte[7];
              tx_reg      <= {tx_byte[6:0], 1'b0};
              bit_cnt_reg <= 4'h1;
              wr_len_o    <= idx_inc;
            end else begin
              state_reg <= bus_ignore;
            end
          end
        end else if (state_reg == bus_rdata) begin
          if (byte_done) begin
            sda_oe_o   <= 1'b0;
            in_ack_reg <= 1'b1;
          end else begin
            sda_oe_o    <= ~tx_reg[7];
            tx_reg      <= {tx_reg[6:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end else if (rx_state && byte_done) begin
          in_ack_reg <= 1'b1;
          sda_oe_o   <= 1'b1;
          case (state_reg)
            bus_addr: begin
              if (!addr_hit) begin
                state_reg  <= bus_ignore;
                in_ack_reg <= 1'b0;
                sda_oe_o   <= 1'b0;
              end else if (shift_reg[0]) begin
                state_reg <= bus_rdata;
                mack_reg  <= 1'b1;
                wr_len_o  <= 2'h0;
              end else begin
                state_reg <= bus_cmd;
              end
            end
            bus_cmd: begin
              cmd_o     <= shift_reg;
              state_reg <= bus_wdata;
              wr_len_o  <= 2'h0;
            end
            default: begin
              if (wr_len_o == 2'h0) begin
                wr_data_o[7:0] <= shift_reg;
                wr_len_o       <= 2'h1;
              end else if (wr_len_o == 2'h1) begin
                wr_data_o[15:8] <= shift_reg;
                wr_len_o        <= 2'h2;
              end else begin
                // surplus bytes are refused
                in_ack_reg <= 1'b0;
                sda_oe_o   <= 1'b0;
              end
            end
          endcase
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> pmbus_host_model.sv
// management bus host: start, stop, byte writes and word reads
// assumes the bench resolves the open-drain wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // clock and bus
  input  wire logic clock_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic [15:0] rdata;
  logic [8:0]  sh;
  event        done;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // 4-clock low and high phases keep the target's 2-flop sampling safe
  task automatic bit_x(input logic v);
    sda_o = v;
    w(2);
    scl_o = 1'b1;
    w(4);
    sh = {sh[7:0], sda_i};
    scl_o = 1'b0;
    w(2);
  endtask
  task automatic start;
    sda_o = 1'b1;
    w(2);
    scl_o = 1'b1;
    w(4);
    sda_o = 1'b0;
    w(4);
    scl_o = 1'b0;
    w(2);
  endtask
  task automatic stop;
    sda_o = 1'b0;
    w(2);
    scl_o = 1'b1;
    w(4);
    sda_o = 1'b1;
    w(4);
  endtask
  // ninth bit: 1 releases for the target's ack, 0 acks a read byte
  task automatic byte_x(input logic [7:0] v, input logic last);
    for (int i = 7; i >= 0; i--) bit_x(v[i]);
    bit_x(last);
  endtask
  task automatic write(input logic [7:0] c, input logic [15:0] d,
                       input int n);
    start;
    byte_x({ADDR, 1'b0}, 1'b1);
    byte_x(c, 1'b1);
    if (n > 0) byte_x(d[7:0], 1'b1);
    if (n > 1) byte_x(d[15:8], 1'b1);
    stop;
  endtask
  task automatic read(input logic [7:0] c);
    start;
    byte_x({ADDR, 1'b0}, 1'b1);
    byte_x(c, 1'b1);
    start;
    byte_x({ADDR, 1'b1}, 1'b1);
    byte_x(8'hFF, 1'b0);
    rdata[7:0] = sh[8:1];
    byte_x(8'hFF, 1'b1);
    rdata[15:8] = sh[8:1];
    stop;
    -> done;
  endtask
endmodule
`default_nettype wire

// >>> test_output_power_sequencer.sv
// self-checking bench for the output power sequencer
// assumes a 1 ms tick of 20 clocks; no other fault, bias lost at the end
`timescale 1ns/1ps
`default_nettype none
module test_output_power_sequencer;
  logic        clock_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        run = 1'b0;
  logic        clr = 1'b0;
  logic        uv = 1'b0;
  logic [15:0] vout = 16'h0000;
  logic        bias = 1'b1;
  logic        scl, hsda, oe, en, ramp, pg, tf, ce, sdo;
  logic [7:0]  rel;
  logic [15:0] exp_q[$];
  logic [15:0] snap;
  event        snap_e;
  int          fails = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic [31:0] rs = 32'd32002;
  logic [7:0]  cm[7] = '{8'h5E, 8'h5F, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64};
  logic [15:0] df[7] = '{16'h0114, 16'h0105, 16'h0000, 16'h0005, 16'h0014,
                         16'h00B9, 16'h0000};
  logic [7:0]  act[3] = '{8'h80, 8'h89, 8'hB9};
  logic [2:0]  en1 = 3'b110;
  logic [2:0]  en2 = 3'b100;
  wire         sda = hsda & (~oe | sdo);
  pmbus_host_model host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl),
                         .sda_o(hsda));
  output_power_sequencer #(.MS_CYCLES(20)) dut (.clock_i(clock_i),
    .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda), .sda_o(sdo),
    .sda_oe_o(oe), .run_request_i(run), .bias_ok_i(bias),
    .other_fault_i(1'b0), .fault_clear_i(clr), .vout_code_i(vout),
    .uv_limit_reached_i(uv), .output_enable_o(en), .ramp_active_o(ramp),
    .ramp_elapsed_o(rel), .power_good_o(pg), .timeout_fault_o(tf),
    .config_error_o(ce));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic tally_and_finish;
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp16(input logic [15:0] got);
    logic [15:0] e;
    e = exp_q.pop_front();
    checks_done++;
    if (got !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, e);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    exp_q.push_back(e);
    host.read(c);
  endtask
  // snapshot {elapsed ms, 000, ramp, pg, timeout, cfg error, enable}
  task automatic pins(input int n, input logic [4:0] e,
                      input logic [7:0] el = 8'h00);
    repeat (n) @(negedge clock_i);
    exp_q.push_back({el, 3'h0, e});
    snap = {rel, 3'h0, ramp, pg, tf, ce, en};
    -> snap_e;
  endtask
  always @(host.done) cmp16(host.rdata);
  always @(snap_e) cmp16(snap);
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      tally_and_finish;
    end
  end
  initial forever #5 clock_i = ~clock_i;
  initial begin
    repeat (16) @(negedge clock_i);
    resetn_i = 1'b1;
    pins(8, 5'b00000);
    host.write(8'h60, 16'h0080, 2);
    host.write(8'h61, 16'h0801, 2);
    host.write(8'h5E, 16'h007A, 2);
    host.write(8'h63, 16'h0080, 2);
    pins(8, 5'b00010);
    for (int i = 0; i < 7; i++) rd(cm[i], df[i]);
    rd(8'hD0, 16'h0801);
    host.write(8'h03, 16'h0000, 0);
    pins(8, 5'b00000);
    rs = xs(rs);
    host.write(8'h60, {9'h000, rs[6:0]}, 2);
    rd(8'h60, {9'h000, rs[6:0]});
    host.write(8'h60, 16'h0002, 2);
    host.write(8'h61, 16'h0003, 2);
    host.write(8'h62, 16'h0005, 2);
    for (int k = 0; k < 3; k++) begin
      host.write(8'h63, {8'h00, act[k]}, 1);
      run = 1'b1;
      pins(30, 5'b00000);
      pins(40, 5'b10001, 8'h01);
      pins(130, 5'b00100);
      pins(420, {en1[k], 3'b010, en1[k]}, 8'(en1[k]));
      pins(540, {en2[k], 3'b010, en2[k]}, 8'(en2[k]));
      run = 1'b0;
      clr = 1'b1;
      pins(100, 5'b00000);
      clr = 1'b0;
    end
    host.write(8'h64, 16'h0003, 2);
    uv = 1'b1;
    vout = 16'h0114;
    run = 1'b1;
    pins(120, 5'b01001);
    vout = 16'h0105;
    pins(5, 5'b01001);
    vout = 16'h0104;
    pins(5, 5'b00001);
    run = 1'b0;
    pins(40, 5'b00001);
    pins(50, 5'b00000);
    bias = 1'b0;
    run = 1'b1;
    pins(60, 5'b00000);
    tally_and_finish;
  end
endmodule
`default_nettype wire
